// ---- pkg/vac_pkg.sv ----
// Purpose: Shared constants for the video amplifier control register bank
// Assumes: Byte-wide registers at 16-bit sub-addresses, one byte used of two
// Notes:   Timing counts derive from the 40 MHz core clock
package vac_pkg;
    // Register sub-addresses
    localparam logic [15:0] ADDR_FIRST      = 16'h0F03;
    localparam logic [15:0] ADDR_MAIN_GAIN  = 16'h0F03;
    localparam logic [15:0] ADDR_BLACK      = 16'h0F04;
    localparam logic [15:0] ADDR_RED_FINE   = 16'h0F05;
    localparam logic [15:0] ADDR_GREEN_FINE = 16'h0F06;
    localparam logic [15:0] ADDR_BLUE_FINE  = 16'h0F07;
    localparam logic [15:0] ADDR_OVL_GAIN   = 16'h0F08;
    localparam logic [15:0] ADDR_RED_CUT    = 16'h0F09;
    localparam logic [15:0] ADDR_GREEN_CUT  = 16'h0F0A;
    localparam logic [15:0] ADDR_BLUE_CUT   = 16'h0F0B;
    localparam logic [15:0] ADDR_CUT_BLACK  = 16'h0F0C;
    localparam logic [15:0] ADDR_HT_BLANK   = 16'h0F0D;
    localparam logic [15:0] ADDR_CLAMP      = 16'h0F0E;
    localparam logic [15:0] ADDR_HT_COLOR3  = 16'h0F0F;
    localparam int          NUM_REGS        = 13;

    // Reset values; unspecified ones held at zero
    localparam logic [7:0] RST_MID   = 8'h80;
    localparam logic [7:0] RST_ZERO  = 8'h00;
    localparam logic [7:0] RST_CLAMP = 8'h10;

    // Writable bit masks, unused bits read zero
    localparam logic [7:0] MASK_FULL   = 8'hFF;
    localparam logic [7:0] MASK_CLAMP  = 8'hFB;
    localparam logic [7:0] MASK_COLOR3 = 8'h0F;

    // Field positions
    localparam int HT_EN_BIT     = 0;
    localparam int SOFT_BLANK_BIT = 7;
    localparam int CLAMP_SRC_BIT = 7;
    localparam int CLAMP_POL_BIT = 6;
    localparam int FLYB_POL_BIT  = 5;
    localparam int CLAMP_W_HI    = 4;
    localparam int CLAMP_W_LO    = 3;
    localparam int CUT_OFS_HI    = 1;
    localparam int COLOR_HI      = 2;
    localparam int TEST_BIT      = 3;

    // Clamp width table, picoseconds, and cycle counts at core clock
    localparam int CLK_PERIOD_PS = 25000;
    localparam int CLAMP_W0_PS   = 330000;
    localparam int CLAMP_W1_PS   = 660000;
    localparam int CLAMP_W2_PS   = 1000000;
    localparam int CLAMP_W3_PS   = 1330000;
    localparam logic [7:0] CLAMP_W0_CYC = 8'(CLAMP_W0_PS / CLK_PERIOD_PS);
    localparam logic [7:0] CLAMP_W1_CYC = 8'(CLAMP_W1_PS / CLK_PERIOD_PS);
    localparam logic [7:0] CLAMP_W2_CYC = 8'(CLAMP_W2_PS / CLK_PERIOD_PS);
    localparam logic [7:0] CLAMP_W3_CYC = 8'(CLAMP_W3_PS / CLK_PERIOD_PS);

    // Display memory and font figures
    localparam int DISP_WORDS     = 512;
    localparam int DISP_WIDTH     = 16;
    localparam int ERASE_AREAS    = 480;
    localparam int ROW_STRIDE     = 32;
    localparam int ROW_USED       = 30;
    localparam int SPARE_INDEX    = 255;
    localparam int SKIP_ROW       = 15;
    localparam int FONT_COUNT     = 448;
    localparam logic [8:0] BLANK_FONT = 9'h000;
endpackage

// ---- rtl/vac_clamp_gen.sv ----
// Purpose: Clamp pulse source: internal from flyback or external pin
// Assumes: Pins already synchronised by the caller
// Notes:   Pulse starts on flyback active edge
`timescale 1ns/1ps
module vac_clamp_gen (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Configuration
    input  wire logic       clampSourceSelect,
    input  wire logic       clampPolarity,
    input  wire logic       flybackPolarity,
    input  wire logic [1:0] clampWidth,
    // Synchronised pins
    input  wire logic       flybackSync,
    input  wire logic       clampPinSync,
    // Result
    output logic            clampPulse
);
    logic       flybackPrev;
    logic [7:0] count;
    logic       next_flybackPrev;
    logic [7:0] next_count;
    logic       next_clampPulse;
    logic       flybackActive;
    logic [7:0] widthCycles;

    always_comb begin
        flybackActive = flybackSync ^ ~flybackPolarity;
        case (clampWidth)
            2'h0: widthCycles = vac_pkg::CLAMP_W0_CYC;
            2'h1: widthCycles = vac_pkg::CLAMP_W1_CYC;
            2'h2: widthCycles = vac_pkg::CLAMP_W2_CYC;
            default: widthCycles = vac_pkg::CLAMP_W3_CYC;
        endcase
        next_flybackPrev = flybackActive;
        next_count = count;
        if (flybackActive && !flybackPrev) begin
            next_count = widthCycles;
        end else if (count != 8'h00) begin
            next_count = count - 8'h01;
        end
        if (clampSourceSelect) begin
            // External pulse; polarity only matters here
            next_clampPulse = clampPinSync ^ clampPolarity;
        end else begin
            next_clampPulse = (next_count != 8'h00);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            // Level seen at release is not an edge; avoids a false pulse after reset
            flybackPrev <= 1'b1;
            count       <= 8'h00;
            clampPulse  <= 1'b0;
        end else begin
            flybackPrev <= next_flybackPrev;
            count       <= next_count;
            clampPulse  <= next_clampPulse;
        end
    end
endmodule

// ---- rtl/vac_regs.sv ----
// Purpose: Amplifier control register bank with clamp and half-tone controls
// Assumes: Host issues single-cycle write and read strobes on core_clk
// Notes:   Display memory and font figures exported as constants only
`timescale 1ns/1ps
module vac_regs (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Register access port
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [15:0] regAddr,
    input  wire logic [15:0] regWriteData,
    output logic      [15:0] regReadData,
    output logic             regReadValid,
    output logic             regAddrError,
    // Pins
    input  wire logic        horizontal_flyback_in,
    input  wire logic        clamp_pulse_in,
    // Amplifier controls
    output logic [7:0]       mainGain,
    output logic [7:0]       blackLevel,
    output logic [7:0]       redFineGain,
    output logic [7:0]       greenFineGain,
    output logic [7:0]       blueFineGain,
    output logic [7:0]       overlayGain,
    output logic [7:0]       redCutoff,
    output logic [7:0]       greenCutoff,
    output logic [7:0]       blueCutoff,
    output logic [7:0]       cutoffBlack,
    output logic [1:0]       cutoffOffset,
    output logic             soft_blank,
    // Half-tone colour selects, gated by enable
    output logic [2:0]       halftoneColor1,
    output logic [2:0]       halftoneColor2,
    output logic [2:0]       halftoneColor3,
    output logic             halftoneActive,
    output logic             test_mode_bit,
    // Clamp
    output logic             clampPulse
);
    localparam logic [7:0] RESETS [vac_pkg::NUM_REGS] = '{
        vac_pkg::RST_MID, vac_pkg::RST_ZERO, vac_pkg::RST_MID, vac_pkg::RST_ZERO,
        vac_pkg::RST_ZERO, vac_pkg::RST_ZERO, vac_pkg::RST_MID, vac_pkg::RST_MID,
        vac_pkg::RST_MID, vac_pkg::RST_ZERO, vac_pkg::RST_ZERO, vac_pkg::RST_CLAMP,
        vac_pkg::RST_ZERO};
    localparam logic [7:0] MASKS [vac_pkg::NUM_REGS] = '{
        vac_pkg::MASK_FULL, vac_pkg::MASK_FULL, vac_pkg::MASK_FULL, vac_pkg::MASK_FULL,
        vac_pkg::MASK_FULL, vac_pkg::MASK_FULL, vac_pkg::MASK_FULL, vac_pkg::MASK_FULL,
        vac_pkg::MASK_FULL, vac_pkg::MASK_FULL, vac_pkg::MASK_FULL, vac_pkg::MASK_CLAMP,
        vac_pkg::MASK_COLOR3};

    // Register slots follow the sub-address order
    localparam int IDX_HT_BLANK = int'(vac_pkg::ADDR_HT_BLANK - vac_pkg::ADDR_FIRST);
    localparam int IDX_CLAMP    = int'(vac_pkg::ADDR_CLAMP - vac_pkg::ADDR_FIRST);
    localparam int IDX_COLOR3   = int'(vac_pkg::ADDR_HT_COLOR3 - vac_pkg::ADDR_FIRST);
    localparam int COLOR_W      = vac_pkg::COLOR_HI + 1;
    localparam int COLOR1_LO    = vac_pkg::HT_EN_BIT + 1;
    localparam int COLOR2_LO    = COLOR1_LO + COLOR_W;

    // Display memory and fonts sit outside this bank; only their figures are kept
    localparam int DISP_ADDR_W  = $clog2(vac_pkg::DISP_WORDS);
    localparam int ROW_SHIFT    = $clog2(vac_pkg::ROW_STRIDE);
    localparam int ERASE_CELLS  = vac_pkg::ERASE_AREAS;
    localparam int FONT_IDX_W   = $clog2(vac_pkg::FONT_COUNT);

    logic [7:0]  regs      [vac_pkg::NUM_REGS];
    logic [7:0]  next_regs [vac_pkg::NUM_REGS];
    logic [15:0] next_regReadData;
    logic        next_regReadValid;
    logic        next_regAddrError;
    logic [15:0] offset;
    logic [3:0]  index;
    logic        hit;
    logic        flybackMeta;
    logic        flybackSync;
    logic        clampMeta;
    logic        clampSync;

    // Index decode; the host sees one byte in the low lane
    // Indices past the last slot are never used: every access needs a hit
    always_comb begin
        offset = regAddr - vac_pkg::ADDR_FIRST;
        index  = offset[3:0];
        hit    = (regAddr >= vac_pkg::ADDR_FIRST) && (regAddr <= vac_pkg::ADDR_HT_COLOR3);
    end

    // One register per entry, masked so unused bits stay zero
    genvar gi;
    generate
        for (gi = 0; gi < vac_pkg::NUM_REGS; gi++) begin : g_reg
            always_comb begin
                next_regs[gi] = regs[gi];
                if (regWrite && hit && (index == 4'(gi))) begin
                    next_regs[gi] = regWriteData[7:0] & MASKS[gi];
                end
            end
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    regs[gi] <= RESETS[gi];
                end else begin
                    regs[gi] <= next_regs[gi];
                end
            end
        end
    endgenerate

    always_comb begin
        next_regReadValid = regRead;
        next_regAddrError = (regRead || regWrite) && !hit;
        next_regReadData  = 16'h0000;
        if (regRead && hit) begin
            next_regReadData = {8'h00, regs[index]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            regReadData  <= 16'h0000;
            regReadValid <= 1'b0;
            regAddrError <= 1'b0;
        end else begin
            regReadData  <= next_regReadData;
            regReadValid <= next_regReadValid;
            regAddrError <= next_regAddrError;
        end
    end

    // Pin synchronisers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            flybackMeta <= 1'b0;
            flybackSync <= 1'b0;
            clampMeta   <= 1'b0;
            clampSync   <= 1'b0;
        end else begin
            flybackMeta <= horizontal_flyback_in;
            flybackSync <= flybackMeta;
            clampMeta   <= clamp_pulse_in;
            clampSync   <= clampMeta;
        end
    end

    // Control outputs registered; one cycle behind the register contents
    logic [7:0] ht;
    logic [7:0] c3;
    always_comb begin
        ht = regs[IDX_HT_BLANK];
        c3 = regs[IDX_COLOR3];
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mainGain       <= vac_pkg::RST_MID;
            blackLevel     <= vac_pkg::RST_ZERO;
            redFineGain    <= vac_pkg::RST_MID;
            greenFineGain  <= vac_pkg::RST_ZERO;
            blueFineGain   <= vac_pkg::RST_ZERO;
            overlayGain    <= vac_pkg::RST_ZERO;
            redCutoff      <= vac_pkg::RST_MID;
            greenCutoff    <= vac_pkg::RST_MID;
            blueCutoff     <= vac_pkg::RST_MID;
            cutoffBlack    <= vac_pkg::RST_ZERO;
            cutoffOffset   <= 2'h0;
            soft_blank     <= 1'b0;
            halftoneColor1 <= 3'h0;
            halftoneColor2 <= 3'h0;
            halftoneColor3 <= 3'h0;
            halftoneActive <= 1'b0;
            test_mode_bit  <= 1'b0;
        end else begin
            mainGain       <= regs[0];
            blackLevel     <= regs[1];
            redFineGain    <= regs[2];
            greenFineGain  <= regs[3];
            blueFineGain   <= regs[4];
            overlayGain    <= regs[5];
            redCutoff      <= regs[6];
            greenCutoff    <= regs[7];
            blueCutoff     <= regs[8];
            cutoffBlack    <= regs[9];
            cutoffOffset   <= regs[IDX_CLAMP][vac_pkg::CUT_OFS_HI:0];
            soft_blank     <= ht[vac_pkg::SOFT_BLANK_BIT];
            halftoneActive <= ht[vac_pkg::HT_EN_BIT];
            // Selections forced to black unless half-tone is on
            halftoneColor1 <= ht[vac_pkg::HT_EN_BIT] ? ht[COLOR1_LO +: COLOR_W] : 3'h0;
            halftoneColor2 <= ht[vac_pkg::HT_EN_BIT] ? ht[COLOR2_LO +: COLOR_W] : 3'h0;
            // Bit order green, red, blue
            halftoneColor3 <= ht[vac_pkg::HT_EN_BIT] ?
                              c3[vac_pkg::COLOR_HI:0] : 3'h0;
            // Passed out for visibility; host is expected to keep it low
            test_mode_bit  <= c3[vac_pkg::TEST_BIT];
        end
    end

    vac_clamp_gen u_clamp (
        .core_clk          (core_clk),
        .rst               (rst),
        .clampSourceSelect (regs[IDX_CLAMP][vac_pkg::CLAMP_SRC_BIT]),
        .clampPolarity     (regs[IDX_CLAMP][vac_pkg::CLAMP_POL_BIT]),
        .flybackPolarity   (regs[IDX_CLAMP][vac_pkg::FLYB_POL_BIT]),
        .clampWidth        (regs[IDX_CLAMP][vac_pkg::CLAMP_W_HI:vac_pkg::CLAMP_W_LO]),
        .flybackSync       (flybackSync),
        .clampPinSync      (clampSync),
        .clampPulse        (clampPulse)
    );
endmodule

// ---- verification/vac_regs_assertions.sv ----
// Purpose: Port-level checks for the amplifier control register bank
// Assumes: Clamp settings shadowed from host writes to the clamp register
// Notes:   Width check skipped when the clamp register changes mid-pulse
`timescale 1ns/1ps
module vac_regs_chk (
    // Clock and reset
    input logic        core_clk,
    input logic        rst,
    // Register port
    input logic        regWrite,
    input logic        regRead,
    input logic [15:0] regAddr,
    input logic [15:0] regWriteData,
    input logic [15:0] regReadData,
    input logic        regReadValid,
    input logic        regAddrError,
    // Pins and outputs
    input logic        clamp_pulse_in,
    input logic [7:0]  mainGain,
    input logic [2:0]  halftoneColor1,
    input logic [2:0]  halftoneColor2,
    input logic [2:0]  halftoneColor3,
    input logic        halftoneActive,
    input logic        clampPulse
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [7:0] cfg;
    logic [7:0] hiCnt;
    logic [7:0] quiet;
    logic       bad;
    logic       cfgWr;
    assign bad = regAddr < 16'h0F03 || regAddr > 16'h0F0F;
    assign cfgWr = regWrite && regAddr == vac_pkg::ADDR_CLAMP;
    always_ff @(posedge core_clk) begin
        cfg <= rst ? 8'h10 : cfgWr ? (regWriteData[7:0] & 8'hFB) : cfg;
        hiCnt <= (rst || !clampPulse) ? 8'h00 : hiCnt + 8'h01;
        quiet <= (rst || cfgWr) ? 8'h00 : (quiet == 8'hFF) ? quiet : quiet + 8'h01;
    end
    function automatic int wexp(logic [1:0] w);
        int ns[4] = '{330, 660, 1000, 1330};
        return ns[w] / 25;
    endfunction
    a_read_valid: assert property (regRead |=> regReadValid)
        else $error("read not answered");
    a_valid_only: assert property (!regRead |=> !regReadValid)
        else $error("read valid without read");
    a_err_unmapped: assert property ((regRead || regWrite) && bad |=>
        regAddrError && regReadData == 16'h0000) else $error("unmapped access missed");
    a_err_mapped: assert property ((regRead || regWrite) && !bad |=> !regAddrError)
        else $error("mapped access flagged");
    a_read_upper: assert property (regReadValid |-> regReadData[15:8] == 8'h00)
        else $error("unused read byte not zero");
    a_gain_mirror: assert property (regWrite && regAddr == vac_pkg::ADDR_MAIN_GAIN ##1
        !(regWrite && regAddr == vac_pkg::ADDR_MAIN_GAIN) |=>
        mainGain == $past(regWriteData[7:0], 2)) else $error("gain mirror wrong");
    a_ht_gate: assert property (!halftoneActive |->
        {halftoneColor1, halftoneColor2, halftoneColor3} == 9'h000)
        else $error("half-tone colour while disabled");
    a_clamp_width: assert property ($fell(clampPulse) && !cfg[7] &&
        quiet > hiCnt + 8'h06 |-> hiCnt == wexp(cfg[4:3])) else $error("clamp width wrong");
    a_ext_follow: assert property ((cfg[7] && quiet > 8'h04 &&
        $stable(clamp_pulse_in)) [*4] |-> clampPulse == (clamp_pulse_in ^ cfg[6]))
        else $error("external clamp not followed");
    c_unmapped: cover property (regRead && bad);
    c_int_pulse: cover property ($fell(clampPulse) && !cfg[7]);
    c_ht_on: cover property (halftoneActive && halftoneColor3 != 3'h0);
endmodule
bind vac_regs vac_regs_chk chk (.core_clk, .rst, .regWrite, .regRead, .regAddr,
    .regWriteData, .regReadData, .regReadValid, .regAddrError, .clamp_pulse_in,
    .mainGain, .halftoneColor1, .halftoneColor2, .halftoneColor3, .halftoneActive,
    .clampPulse);

// ---- verification/vac_host_model.sv ----
// Purpose: Bus host model driving the register port
// Assumes: Strobes change at the falling edge as one-cycle pulses
// Notes:   Released lines carry the inverse of the last value
`timescale 1ns/1ps
module vac_host_model (
    // Clock
    input  logic        core_clk,
    // Register port
    output logic        regWrite,
    output logic        regRead,
    output logic [15:0] regAddr,
    output logic [15:0] regWriteData,
    input  logic [15:0] regReadData,
    input  logic        regReadValid,
    input  logic        regAddrError
);
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 16'h0000;
        regWriteData = 16'h0000;
    end
    // Two-byte transfer, register value in the low byte
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge core_clk);
        regWrite = 1'b1;
        regAddr = a;
        regWriteData = (a == vac_pkg::ADDR_HT_COLOR3) ? (d & 16'hFFF7) : d;
        @(negedge core_clk);
        regWrite = 1'b0;
        regAddr = ~a;
        regWriteData = ~regWriteData;
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] q,
                      output logic e, output logic v);
        @(negedge core_clk);
        regRead = 1'b1;
        regAddr = a;
        @(negedge core_clk);
        regRead = 1'b0;
        regAddr = ~a;
        q = regReadData;
        e = regAddrError;
        v = regReadValid;
    endtask
endmodule

// ---- verification/tb.sv ----
// Purpose: Self-checking bench for the amplifier control register bank
// Assumes: Inputs change at the falling edge
// Notes:   Flyback pulses stand still between frames
`timescale 1ns/1ps
module tb;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        flyIn = 1'b0;
    logic        clpIn = 1'b0;
    logic        regWrite, regRead, regReadValid, regAddrError, htAct, clampPulse, e, v;
    logic [15:0] regAddr, regWriteData, regReadData, q, a;
    logic [2:0]  hc1, hc2, hc3;
    logic [1:0]  cutOfs;
    logic        softBlank, testBit;
    wire  [9:0][7:0] mir;
    logic [31:0] seed = 32'h7E442291;
    logic [31:0] r;
    int          fail_count = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          n;
    always #12.5 core_clk = ~core_clk;
    vac_host_model host (.core_clk, .regWrite, .regRead, .regAddr, .regWriteData,
        .regReadData, .regReadValid, .regAddrError);
    vac_regs DUT (.core_clk, .rst, .regWrite, .regRead, .regAddr, .regWriteData,
        .regReadData, .regReadValid, .regAddrError, .horizontal_flyback_in(flyIn),
        .clamp_pulse_in(clpIn), .mainGain(mir[0]), .blackLevel(mir[1]),
        .redFineGain(mir[2]), .greenFineGain(mir[3]), .blueFineGain(mir[4]),
        .overlayGain(mir[5]), .redCutoff(mir[6]), .greenCutoff(mir[7]),
        .blueCutoff(mir[8]), .cutoffBlack(mir[9]), .cutoffOffset(cutOfs),
        .soft_blank(softBlank),
        .halftoneColor1(hc1), .halftoneColor2(hc2), .halftoneColor3(hc3),
        .halftoneActive(htAct), .test_mode_bit(testBit), .clampPulse);
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic logic [7:0] rstv(logic [15:0] x);
        if (x inside {16'h0F03, 16'h0F05, [16'h0F09:16'h0F0B]}) return 8'h80;
        return (x == 16'h0F0E) ? 8'h10 : 8'h00;
    endfunction
    function automatic logic [7:0] expd(logic [15:0] x, logic [15:0] d);
        return d[7:0] & (x == 16'h0F0E ? 8'hFB : x == 16'h0F0F ? 8'h07 : 8'hFF);
    endfunction
    function automatic int wexp(logic [1:0] w);
        int ns[4] = '{330, 660, 1000, 1330};
        return ns[w] / 25;
    endfunction
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Idle level is the inactive one, so only the pulse itself is an edge
    task pulse_count(input logic act, output int c);
        c = 0;
        @(negedge core_clk);
        flyIn = act;
        for (int i = 0; i < 84; i++) begin
            @(negedge core_clk);
            if (i == 3) flyIn = ~act;
            c += (clampPulse === 1'b1);
        end
    endtask
    task end_sim();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 6000) begin
            fail_count++;
            end_sim();
        end
    end
    initial begin
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        for (int i = 16'h0F02; i <= 16'h0F10; i++) begin
            a = 16'(i);
            host.rd(a, q, e, v);
            cmp(q, (i == 16'h0F02 || i == 16'h0F10) ? 16'h0000 : {8'h00, rstv(a)});
            cmp(e, i == 16'h0F02 || i == 16'h0F10);
        end
        repeat (3) begin
            r = rnd();
            a = {1'b1, r[14:0]};
            host.wr(a, r[31:16]);
            host.rd(a, q, e, v);
            cmp({q[14:0], e}, 16'h0001);
        end
        for (int k = 0; k < 39; k++) begin
            a = 16'h0F03 + 16'(k % 13);
            r = (k < 13) ? 32'hFFFFFFFF : rnd();
            host.wr(a, r[15:0]);
            host.rd(a, q, e, v);
            cmp(q, {8'h00, expd(a, r[15:0])});
            cmp(v, 1'b1);
            if (k % 13 < 10) cmp(mir[k % 13], {8'h00, expd(a, r[15:0])});
            if (a == 16'h0F0D) cmp(softBlank, r[7]);
            if (a == 16'h0F0E) cmp(cutOfs, r[1:0]);
            cmp(testBit, 1'b0);
        end
        cmp(16'(vac_pkg::DISP_WORDS), 16'h0200);
        cmp(16'(vac_pkg::DISP_WIDTH), 16'h0010);
        cmp(16'(vac_pkg::SPARE_INDEX), 16'h00FF);
        cmp(16'(vac_pkg::ERASE_AREAS), 16'h01E0);
        cmp(16'(vac_pkg::FONT_COUNT), 16'h01C0);
        cmp(16'(vac_pkg::BLANK_FONT), 16'h0000);
        $display("register test done");
        for (int c = 0; c < 16; c++) begin
            r = rnd();
            host.wr(16'h0F0D, {8'h00, r[7:1], c[3]});
            host.wr(16'h0F0F, {12'h000, 1'b0, c[2:0]});
            repeat (3) @(negedge core_clk);
            cmp({hc3, hc2, hc1}, c[3] ? {c[2:0], r[6:1]} : 9'h000);
            cmp(htAct, c[3]);
        end
        $display("half-tone test done");
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            host.wr(16'h0F0E, {8'h00, 1'b0, r[0], k[2], k[1:0], 3'h0});
            flyIn = ~k[2];
            repeat (70) @(negedge core_clk);
            pulse_count(k[2], n);
            cmp(16'(n), 16'(wexp(k[1:0])));
        end
        r = rnd();
        host.wr(16'h0F0E, {8'h00, 1'b1, r[0], r[5:3], 3'h0});
        repeat (6) begin
            clpIn = 1'(rnd());
            repeat (5) @(negedge core_clk);
            cmp(clampPulse, clpIn ^ r[0]);
        end
        clpIn = r[0];
        repeat (5) @(negedge core_clk);
        pulse_count(1'b1, n);
        cmp(16'(n), 16'h0000);
        $display("clamp test done");
        rst = 1'b1;
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        host.rd(16'h0F0E, q, e, v);
        cmp(q, 16'h0010);
        host.rd(16'h0F03, q, e, v);
        cmp(q, 16'h0080);
        $display("second reset test done");
        end_sim();
    end
endmodule
